// >>> core/esobj_top.sv
// Device type word, fault summary and fault history stack objects
`timescale 1ns/1ps
`include "esobj_defs.svh"
`default_nettype none

module esobj_top #(
  parameter logic [7:0] MOTOR_KIND = `ESOBJ_KIND_BOTH, // Arbitrary default kind
  parameter int         HIST_DEPTH = `ESOBJ_HIST_DEPTH
) (
  input  wire logic                  sys_clk_in,
  input  wire logic                  srst_in,
  input  wire logic                  req_valid_in,
  input  wire esobj_pkg::esobj_req_t req_in,
  input  wire logic [7:0]            fault_active_in,
  input  wire logic                  log_valid_in,
  input  wire esobj_pkg::esobj_log_t log_entry_in,
  output logic                       rsp_valid_out,
  output var esobj_pkg::esobj_rsp_t  rsp_out,
  output logic [7:0]                 fault_summary_out,
  output logic [7:0]                 fault_count_out
);

  ////////////////////////////////////////////////////////////////////////////
  // Fixed type word

  localparam logic [31:0] TYPE_WORD = {`ESOBJ_TYPE_TOP, MOTOR_KIND, `ESOBJ_PROFILE};

  ////////////////////////////////////////////////////////////////////////////
  // Fault summary

  logic [7:0] fault_summary;
  logic [7:0] next_summary;

  always_comb begin
    next_summary = fault_active_in & `ESOBJ_SUMMARY_MASK;
  end

  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      fault_summary <= `ESOBJ_SUMMARY_RST;
    end else begin
      fault_summary <= next_summary;
    end
  end

  assign fault_summary_out = fault_summary;

  ////////////////////////////////////////////////////////////////////////////
  // Fault history stack and count

  logic [31:0] hist       [HIST_DEPTH];
  logic [31:0] next_hist  [HIST_DEPTH];
  logic [7:0]  fault_count;
  logic [7:0]  next_count;
  logic [7:0]  count_base;
  logic        count_clear;
  logic [31:0] log_word;

  assign log_word = {log_entry_in.cause, log_entry_in.fclass, log_entry_in.code};

  genvar g;
  generate
    for (g = 0; g < HIST_DEPTH; g++) begin : g_hist
      if (g == 0) begin : g_head
        assign next_hist[g] = log_valid_in ? log_word : hist[g];
      end else begin : g_tail
        assign next_hist[g] = log_valid_in ? hist[g-1] : hist[g];
      end
    end
  endgenerate

  always_comb begin
    count_clear = req_valid_in && req_in.write
                  && (req_in.index == `ESOBJ_IDX_HISTORY)
                  && (req_in.sub == `ESOBJ_SUB_COUNT)
                  && (req_in.wdata == `ESOBJ_HIST_RST);
    count_base = count_clear ? `ESOBJ_COUNT_RST : fault_count;
    next_count = count_base;
    if (log_valid_in && (count_base != `ESOBJ_COUNT_MAX)) begin
      next_count = 8'(count_base + 8'h01);
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      fault_count <= `ESOBJ_COUNT_RST;
      for (int i = 0; i < HIST_DEPTH; i++) begin
        hist[i] <= `ESOBJ_HIST_RST;
      end
    end else begin
      fault_count <= next_count;
      for (int i = 0; i < HIST_DEPTH; i++) begin
        hist[i] <= next_hist[i];
      end
    end
  end

  assign fault_count_out = fault_count;

  ////////////////////////////////////////////////////////////////////////////
  // Dictionary access

  esobj_pkg::esobj_rsp_t rsp;
  esobj_pkg::esobj_rsp_t next_rsp;
  logic                  rsp_valid;
  logic                  next_rsp_valid;

  always_comb begin
    next_rsp_valid      = req_valid_in;
    next_rsp.abort      = 1'b0;
    next_rsp.abort_code = `ESOBJ_ABORT_NONE;
    next_rsp.rdata      = 32'h00000000;
    if (req_valid_in) begin
      unique case (req_in.index)
        `ESOBJ_IDX_TYPE: begin
          if (req_in.sub != `ESOBJ_SUB_COUNT) begin
            next_rsp.abort      = 1'b1;
            next_rsp.abort_code = `ESOBJ_ABORT_NOSUB;
          end else if (req_in.write) begin
            next_rsp.abort      = 1'b1;
            next_rsp.abort_code = `ESOBJ_ABORT_RO;
          end else begin
            next_rsp.rdata = TYPE_WORD;
          end
        end
        `ESOBJ_IDX_SUMMARY: begin
          if (req_in.sub != `ESOBJ_SUB_COUNT) begin
            next_rsp.abort      = 1'b1;
            next_rsp.abort_code = `ESOBJ_ABORT_NOSUB;
          end else if (req_in.write) begin
            next_rsp.abort      = 1'b1;
            next_rsp.abort_code = `ESOBJ_ABORT_RO;
          end else begin
            next_rsp.rdata = {24'h000000, fault_summary};
          end
        end
        `ESOBJ_IDX_HISTORY: begin
          if (req_in.sub == `ESOBJ_SUB_COUNT) begin
            if (req_in.write && (req_in.wdata != `ESOBJ_HIST_RST)) begin
              next_rsp.abort      = 1'b1;
              next_rsp.abort_code = `ESOBJ_ABORT_VALUE;
            end else if (!req_in.write) begin
              next_rsp.rdata = {24'h000000, fault_count};
            end
          end else if (req_in.sub <= `ESOBJ_HIST_TOP) begin
            if (req_in.write) begin
              next_rsp.abort      = 1'b1;
              next_rsp.abort_code = `ESOBJ_ABORT_RO;
            end else if (fault_count == `ESOBJ_COUNT_RST) begin
              next_rsp.abort      = 1'b1;
              next_rsp.abort_code = `ESOBJ_ABORT_EMPTY;
            end else begin
              next_rsp.rdata = hist[3'(req_in.sub - 8'h01)];
            end
          end else begin
            next_rsp.abort      = 1'b1;
            next_rsp.abort_code = `ESOBJ_ABORT_NOSUB;
          end
        end
        default: begin
          next_rsp.abort      = 1'b1;
          next_rsp.abort_code = `ESOBJ_ABORT_NOOBJ;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      rsp_valid <= 1'b0;
      rsp       <= '0;
    end else begin
      rsp_valid <= next_rsp_valid;
      rsp       <= next_rsp;
    end
  end

  assign rsp_valid_out = rsp_valid;
  assign rsp_out       = rsp;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (srst_in);

  sequence type_read_s;
    req_valid_in && !req_in.write && req_in.index == `ESOBJ_IDX_TYPE
      && req_in.sub == `ESOBJ_SUB_COUNT;
  endsequence

  sequence type_write_s;
    req_valid_in && req_in.write && req_in.index == `ESOBJ_IDX_TYPE
      && req_in.sub == `ESOBJ_SUB_COUNT;
  endsequence

  sequence empty_read_s;
    req_valid_in && !req_in.write && req_in.index == `ESOBJ_IDX_HISTORY
      && req_in.sub != `ESOBJ_SUB_COUNT && req_in.sub <= `ESOBJ_HIST_TOP
      && fault_count == `ESOBJ_COUNT_RST;
  endsequence

  sequence hist_write_s;
    req_valid_in && req_in.write && req_in.index == `ESOBJ_IDX_HISTORY
      && req_in.sub != `ESOBJ_SUB_COUNT && req_in.sub <= `ESOBJ_HIST_TOP;
  endsequence

  sequence count_bad_write_s;
    req_valid_in && req_in.write && req_in.index == `ESOBJ_IDX_HISTORY
      && req_in.sub == `ESOBJ_SUB_COUNT && req_in.wdata != `ESOBJ_HIST_RST;
  endsequence

  type_word_read_a: assert property (
    type_read_s |=> rsp_valid_out && !rsp_out.abort
      && rsp_out.rdata[15:0] == `ESOBJ_PROFILE && rsp_out.rdata[23:16] == MOTOR_KIND)
    else $error("type word read wrong");

  type_write_reject_a: assert property (
    type_write_s |=> rsp_out.abort && rsp_out.abort_code == `ESOBJ_ABORT_RO)
    else $error("type word write not refused");

  summary_track_a: assert property (
    ##1 fault_summary_out == ($past(fault_active_in) & `ESOBJ_SUMMARY_MASK))
    else $error("summary does not follow faults");

  summary_unused_a: assert property (
    !fault_summary_out[`ESOBJ_BIT_UNUSED])
    else $error("unused summary bit set");

  history_shift_a: assert property (
    log_valid_in |=> hist[0] == $past(log_word) && hist[1] == $past(hist[0])
      && hist[HIST_DEPTH-1] == $past(hist[HIST_DEPTH-2]))
    else $error("history did not shift");

  entry_layout_a: assert property (
    log_valid_in |=> hist[0][31:24] == $past(log_entry_in.cause)
      && hist[0][23:16] == $past(log_entry_in.fclass))
    else $error("entry fields misplaced");

  count_step_a: assert property (
    log_valid_in && !count_clear && fault_count != `ESOBJ_COUNT_MAX
      |=> fault_count_out == 8'($past(fault_count) + 8'h01))
    else $error("count did not advance");

  count_clear_a: assert property (
    count_clear && !log_valid_in |=> fault_count_out == `ESOBJ_COUNT_RST
      ##1 ($past(log_valid_in) || fault_count_out == `ESOBJ_COUNT_RST))
    else $error("count clear failed");

  empty_abort_a: assert property (
    empty_read_s |=> rsp_valid_out && rsp_out.abort
      && rsp_out.abort_code == `ESOBJ_ABORT_EMPTY)
    else $error("empty history read not refused");

  rsp_answer_a: assert property (
    req_valid_in |=> rsp_valid_out)
    else $error("request got no answer");

  hist_write_reject_a: assert property (
    hist_write_s |=> rsp_valid_out && rsp_out.abort && rsp_out.abort_code == `ESOBJ_ABORT_RO)
    else $error("history entry write not refused");

  hist_keep_a: assert property (
    !log_valid_in |=> hist[0] == $past(hist[0]) && hist[1] == $past(hist[1])
      && hist[HIST_DEPTH-1] == $past(hist[HIST_DEPTH-1]))
    else $error("history changed without a log");

  count_value_reject_a: assert property (
    count_bad_write_s |=> rsp_out.abort && rsp_out.abort_code == `ESOBJ_ABORT_VALUE)
    else $error("nonzero count write not refused");

  count_hold_a: assert property (
    !log_valid_in && !count_clear |=> $stable(fault_count_out))
    else $error("count moved without a log");

  count_saturate_a: assert property (
    log_valid_in && !count_clear && fault_count == `ESOBJ_COUNT_MAX
      |=> fault_count_out == `ESOBJ_COUNT_MAX)
    else $error("count wrapped");

  summary_read_a: assert property (
    req_valid_in && !req_in.write && req_in.index == `ESOBJ_IDX_SUMMARY
      && req_in.sub == `ESOBJ_SUB_COUNT
      |=> rsp_out.rdata == {24'h000000, $past(fault_summary)})
    else $error("summary read wrong");

endmodule

`default_nettype wire

// >>> core/esobj_defs.svh
// Constants for the error and status object bank
`ifndef ESOBJ_DEFS_SVH
`define ESOBJ_DEFS_SVH

`define ESOBJ_IDX_TYPE      16'h1000
`define ESOBJ_IDX_SUMMARY   16'h1001
`define ESOBJ_IDX_HISTORY   16'h1003
`define ESOBJ_SUB_COUNT     8'h00
`define ESOBJ_HIST_DEPTH    8
`define ESOBJ_HIST_TOP      8'h08

`define ESOBJ_KIND_BLDC     8'h02
`define ESOBJ_KIND_STEPPER  8'h04
`define ESOBJ_KIND_BOTH     8'h06
`define ESOBJ_PROFILE       16'h0192
`define ESOBJ_TYPE_TOP      8'h00

`define ESOBJ_BIT_GENERAL   0
`define ESOBJ_BIT_CURRENT   1
`define ESOBJ_BIT_SUPPLY    2
`define ESOBJ_BIT_TEMP      3
`define ESOBJ_BIT_LINK      4
`define ESOBJ_BIT_PROFILE   5
`define ESOBJ_BIT_UNUSED    6
`define ESOBJ_BIT_VENDOR    7
`define ESOBJ_SUMMARY_MASK  8'hBF

`define ESOBJ_SUMMARY_RST   8'h00
`define ESOBJ_COUNT_RST     8'h00
`define ESOBJ_COUNT_MAX     8'hFF
`define ESOBJ_HIST_RST      32'h00000000

`define ESOBJ_ABORT_NONE    32'h00000000
`define ESOBJ_ABORT_EMPTY   32'h08000024
`define ESOBJ_ABORT_RO      32'h06010002
`define ESOBJ_ABORT_NOOBJ   32'h06020000
`define ESOBJ_ABORT_NOSUB   32'h06090011
`define ESOBJ_ABORT_VALUE   32'h06090030

`endif

// >>> core/esobj_pkg.sv
// Types for the error and status object bank
`default_nettype none
package esobj_pkg;

  typedef struct packed {
    logic        write;
    logic [15:0] index;
    logic [7:0]  sub;
    logic [31:0] wdata;
  } esobj_req_t;

  typedef struct packed {
    logic        abort;
    logic [31:0] abort_code;
    logic [31:0] rdata;
  } esobj_rsp_t;

  typedef struct packed {
    logic [7:0]  cause;
    logic [7:0]  fclass;
    logic [15:0] code;
  } esobj_log_t;

endpackage
`default_nettype wire

// >>> verif/esobj_master.sv
// Fieldbus master model issuing dictionary accesses
`timescale 1ns/1ps
`default_nettype none
module esobj_master (
  input  wire logic                  clk_in,
  input  wire logic                  rsp_valid_in,
  input  wire esobj_pkg::esobj_rsp_t rsp_in,
  output logic                       req_valid_out,
  output var esobj_pkg::esobj_req_t  req_out
);
  initial begin
    req_valid_out = 1'b0;
    req_out = '0;
  end
  // One access; request held over the taking edge, then released
  task automatic access(input esobj_pkg::esobj_req_t r, output esobj_pkg::esobj_rsp_t rsp,
                        output logic ok);
    ok = 1'b0;
    rsp = '0;
    @(negedge clk_in);
    req_out = r;
    req_valid_out = 1'b1;
    @(negedge clk_in);
    req_valid_out = 1'b0;
    req_out = ~r;
    for (int n = 0; n < 4 && !ok; n++) begin
      if (rsp_valid_in === 1'b1) begin
        ok = 1'b1;
        rsp = rsp_in;
      end else begin
        @(negedge clk_in);
      end
    end
  endtask
endmodule
`default_nettype wire

// >>> verif/error_status_objects_test.sv
// Self-checking bench for the error and status object bank
`timescale 1ns/1ps
`default_nettype none
module error_status_objects_test;
  localparam logic [7:0] KIND = 8'h06;
  localparam logic [31:0] RO = 32'h06010002;
  logic                  sys_clk_in = 1'b0;
  logic                  srst_in = 1'b1;
  logic                  req_valid;
  esobj_pkg::esobj_req_t req;
  logic [7:0]            fault_active_in = 8'h00;
  logic                  log_valid_in = 1'b0;
  esobj_pkg::esobj_log_t log_entry_in = '0;
  logic                  rsp_valid_out;
  esobj_pkg::esobj_rsp_t rsp_out;
  logic [7:0]            fault_summary_out;
  logic [7:0]            fault_count_out;
  int                    failures = 0;
  int                    checked = 0;
  logic [31:0]           hist [8];
  logic [7:0]            cnt = 8'h00;
  always #12.5 sys_clk_in = ~sys_clk_in;
  esobj_top #(.MOTOR_KIND(KIND), .HIST_DEPTH(8)) dut_u (
    .sys_clk_in(sys_clk_in), .srst_in(srst_in), .req_valid_in(req_valid), .req_in(req),
    .fault_active_in(fault_active_in), .log_valid_in(log_valid_in),
    .log_entry_in(log_entry_in), .rsp_valid_out(rsp_valid_out), .rsp_out(rsp_out),
    .fault_summary_out(fault_summary_out), .fault_count_out(fault_count_out));
  esobj_master master_u (.clk_in(sys_clk_in), .rsp_valid_in(rsp_valid_out),
    .rsp_in(rsp_out), .req_valid_out(req_valid), .req_out(req));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic test_done;
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // Access with expected abort code (zero means accepted) and read data
  task automatic acc(input logic w, input logic [15:0] idx, input logic [7:0] sub,
                     input logic [31:0] wd, input logic [31:0] code, input logic [31:0] data);
    esobj_pkg::esobj_rsp_t r;
    logic ok;
    master_u.access({w, idx, sub, wd}, r, ok);
    if (ok !== 1'b1) begin
      failures++;
      test_done();
    end else begin
      check("abort", {31'h0, r.abort}, {31'h0, code != 32'h0});
      check("abort code", r.abort_code, code);
      if (code == 32'h0) check("read data", r.rdata, data);
    end
  endtask
  function automatic logic [31:0] entry_abort();
    return (cnt == 8'h00) ? 32'h08000024 : 32'h00000000;
  endfunction
  task automatic log_one(input logic [31:0] w);
    @(negedge sys_clk_in);
    log_valid_in = 1'b1;
    log_entry_in = w;
    @(negedge sys_clk_in);
    log_valid_in = 1'b0;
    log_entry_in = ~w;
    for (int k = 7; k > 0; k--) hist[k] = hist[k-1];
    hist[0] = w;
    if (cnt != 8'hFF) cnt++;
  endtask
  task automatic check_stack;
    check("count", {24'h0, fault_count_out}, {24'h0, cnt});
    acc(1'b0, 16'h1003, 8'h00, 32'h0, 32'h0, {24'h0, cnt});
    for (int k = 1; k <= 8; k++) begin
      acc(1'b0, 16'h1003, k[7:0], 32'h0, entry_abort(), hist[k-1]);
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [7:0] f;
    void'($urandom(32'h197E));
    for (int k = 0; k < 8; k++) hist[k] = 32'h0;
    repeat (5) @(negedge sys_clk_in);
    srst_in = 1'b0;
    acc(1'b0, 16'h1000, 8'h00, 32'h0, 32'h0, {8'h00, KIND, 16'h0192});
    acc(1'b1, 16'h1000, 8'h00, $urandom, RO, 32'h0);
    acc(1'b0, 16'h1000, 8'h00, 32'h0, 32'h0, {8'h00, KIND, 16'h0192});
    acc(1'b1, 16'h1001, 8'h00, 32'h000000FF, RO, 32'h0);
    acc(1'b0, 16'h1001, 8'h00, 32'h0, 32'h0, 32'h0);
    acc(1'b1, 16'h1003, 8'h01, $urandom, RO, 32'h0);
    acc(1'b0, 16'h1000, 8'h01, 32'h0, 32'h06090011, 32'h0);
    acc(1'b0, 16'h1003, 8'h09, 32'h0, 32'h06090011, 32'h0);
    acc(1'b0, 16'h1002, 8'h00, 32'h0, 32'h06020000, 32'h0);
    check_stack();
    for (int i = 0; i < 10; i++) begin
      f = (i == 0) ? 8'hFF : (i == 9) ? 8'h00 : 8'($urandom);
      @(negedge sys_clk_in);
      fault_active_in = f;
      @(negedge sys_clk_in);
      check("summary", {24'h0, fault_summary_out}, {24'h0, f & 8'hBF});
      acc(1'b0, 16'h1001, 8'h00, 32'h0, 32'h0, {24'h0, f & 8'hBF});
    end
    for (int i = 0; i < 9; i++) log_one($urandom);
    acc(1'b1, 16'h1003, 8'h03, $urandom, RO, 32'h0);
    check_stack();
    acc(1'b1, 16'h1003, 8'h00, 32'h00000005, 32'h06090030, 32'h0);
    check_stack();
    acc(1'b1, 16'h1003, 8'h00, 32'h0, 32'h0, 32'h0);
    cnt = 8'h00;
    check_stack();
    log_one($urandom);
    check_stack();
    for (int i = 0; i < 260; i++) log_one($urandom);
    check_stack();
    test_done();
  end
endmodule
`default_nettype wire
